/* hdl/ppaf_port_pins.v */
/*
 port pin logic: analog input port mode control, bidirectional port with
 pull-up style drive, alternate function muxing, qualified reset request.
 assumes pins are resolved outside from the output enables; the pull-up is
 modelled by the outside wire when the enable is low.
*/
// How it works
// RL1: analog port is eight inputs, never driven
// RL2: reset leaves every analog pin analog
// RL3: writing zero selects digital input path
// RL4: latch one releases pin to pull-up, input
// RL5: reset request needs 24 high cycles
// RL6: each ext irq edge or level selectable
// RL7: each ext irq has priority bit
// RL8: ext irq pins gate matching timers
// RL9: serial pins: sync clock/data, async txd/rxd
// RL10: spi slave select from analog bit five
// RL11: bit three: irq, miso or pwm
// RL12: zero latch drives low, read pin level; with pwm routed, bit three follows the pwm level and ignores the latch
`timescale 1ns/1ps
`include "ppaf_defines.vh"
module ppaf_port_pins #(
    parameter W          = `PPAF_PORT_W,
    parameter RST_CYCLES = `PPAF_RST_CYCLES
) (
    clk,
    sys_rst,
    reset_pin_in,
    ana_wr,
    ana_wdata,
    ana_pin_in,
    ana_mode_rd,
    ana_digital_rd,
    spi_ss_n,
    bidir_wr,
    bidir_wdata,
    bidir_pin_in,
    bidir_pin_out,
    bidir_pin_oe,
    bidir_rd,
    uart_sync_mode,
    uart_txd,
    uart_sclk,
    uart_rx_dout,
    uart_rx_doe,
    uart_rx_din,
    spi_miso_en,
    spi_miso_out,
    spi_miso_in,
    pwm_route_en,
    pwm_output_first,
    irq_edge_mode,
    irq_prio_cfg,
    irq_clr,
    irq_req,
    irq_prio,
    timer_gate,
    core_rst_req
);
    input  wire         clk;
    input  wire         sys_rst;
    input  wire         reset_pin_in;
    input  wire         ana_wr;
    input  wire [W-1:0] ana_wdata;
    input  wire [W-1:0] ana_pin_in;
    output reg  [W-1:0] ana_mode_rd;
    output reg  [W-1:0] ana_digital_rd;
    output reg          spi_ss_n;
    input  wire         bidir_wr;
    input  wire [W-1:0] bidir_wdata;
    input  wire [W-1:0] bidir_pin_in;
    output reg  [W-1:0] bidir_pin_out;
    output reg  [W-1:0] bidir_pin_oe;
    output reg  [W-1:0] bidir_rd;
    input  wire         uart_sync_mode;
    input  wire         uart_txd;
    input  wire         uart_sclk;
    input  wire         uart_rx_dout;
    input  wire         uart_rx_doe;
    output reg          uart_rx_din;
    input  wire         spi_miso_en;
    input  wire         spi_miso_out;
    output reg          spi_miso_in;
    input  wire         pwm_route_en;
    input  wire         pwm_output_first;
    input  wire [1:0]   irq_edge_mode;
    input  wire [1:0]   irq_prio_cfg;
    input  wire [1:0]   irq_clr;
    output reg  [1:0]   irq_req;
    output reg  [1:0]   irq_prio;
    output reg  [1:0]   timer_gate;
    output reg          core_rst_req;

    reg  [W-1:0] ana_mode_q;     // 1 = analog, 0 = digital input
    reg  [W-1:0] bidir_latch_q;
    reg  [1:0]   irq_prev_q;
    reg  [`PPAF_RST_CNT_W-1:0] rst_cnt_q;
    reg  [W-1:0] pin_out_d;
    reg  [W-1:0] pin_oe_d;
    reg  [1:0]   bit3_sel;
    reg  [1:0]   irq_set;
    wire [W-1:0] ana_sync;
    wire [W-1:0] bidir_sync;
    wire         rst_sync;
    wire [1:0]   irq_lvl_n;

    // pin synchronisers
    ppaf_sync2 #(.W(W), .INIT(0)) u_sync_ana (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (ana_pin_in),
        .q       (ana_sync)
    );
    ppaf_sync2 #(.W(W), .INIT(`PPAF_BIDIR_RST)) u_sync_bidir (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (bidir_pin_in),
        .q       (bidir_sync)
    );
    ppaf_sync2 #(.W(1), .INIT(0)) u_sync_rst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (reset_pin_in),
        .q       (rst_sync)
    );

    // interrupt pins are active low levels on bits two and three
    assign irq_lvl_n = {bidir_sync[`PPAF_IRQ1_BIT], bidir_sync[`PPAF_IRQ0_BIT]};

    // bit three routing select, pwm has precedence over miso
    always @* begin
        bit3_sel = `PPAF_SEL_GPIO;
        if (pwm_route_en)
            bit3_sel = `PPAF_SEL_PWM; // RL11
        else if (spi_miso_en)
            bit3_sel = `PPAF_SEL_MISO; // RL11
    end

    // bidirectional drive: low only when the source is zero, else released
    always @* begin
        pin_out_d = {W{1'b0}};
        pin_oe_d  = ~bidir_latch_q; // RL12 RL4
        // serial pins
        if (uart_sync_mode) begin
            pin_oe_d[`PPAF_TXD_BIT] = ~(uart_sclk & bidir_latch_q[`PPAF_TXD_BIT]); // RL9
            pin_oe_d[`PPAF_RXD_BIT] = (uart_rx_doe & ~uart_rx_dout)
                                      | ~bidir_latch_q[`PPAF_RXD_BIT]; // RL9
        end else begin
            pin_oe_d[`PPAF_TXD_BIT] = ~(uart_txd & bidir_latch_q[`PPAF_TXD_BIT]); // RL9
        end
        case (bit3_sel)
            `PPAF_SEL_PWM:
                pin_oe_d[`PPAF_IRQ1_BIT] = ~pwm_output_first; // RL11
            `PPAF_SEL_MISO:
                pin_oe_d[`PPAF_IRQ1_BIT] = ~(spi_miso_out & bidir_latch_q[`PPAF_IRQ1_BIT]);
            `PPAF_SEL_GPIO:
                pin_oe_d[`PPAF_IRQ1_BIT] = ~bidir_latch_q[`PPAF_IRQ1_BIT];
            default:
                pin_oe_d[`PPAF_IRQ1_BIT] = 1'b0;
        endcase
    end

    // interrupt event detection: falling edge on edge mode bits only; low level is taken in the flag update
    always @* begin
        irq_set = irq_edge_mode & irq_prev_q & ~irq_lvl_n; // RL6
    end

    // port latches and interrupt flags
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ana_mode_q    <= `PPAF_ANA_RST; // RL2
            bidir_latch_q <= `PPAF_BIDIR_RST;
            irq_prev_q    <= 2'h3;
            irq_req       <= 2'h0;
        end else begin
            if (ana_wr)
                ana_mode_q <= ana_wdata; // RL3
            if (bidir_wr)
                bidir_latch_q <= bidir_wdata; // RL12
            irq_prev_q <= irq_lvl_n;
            // edge flags: set wins over clear; level mode follows the pin
            irq_req <= (irq_edge_mode & ((irq_req & ~irq_clr) | irq_set))
                       | (~irq_edge_mode & ~irq_lvl_n); // RL6
        end
    end

    // reset qualifier: count consecutive high cycles
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_q    <= {`PPAF_RST_CNT_W{1'b0}};
            core_rst_req <= 1'b0;
        end else if (!rst_sync) begin
            rst_cnt_q    <= {`PPAF_RST_CNT_W{1'b0}};
            core_rst_req <= 1'b0;
        end else if (rst_cnt_q < RST_CYCLES[`PPAF_RST_CNT_W-1:0] - 1'b1) begin
            rst_cnt_q <= rst_cnt_q + 1'b1; // RL5
        end else begin
            core_rst_req <= 1'b1; // RL5
        end
    end

    // registered outputs
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bidir_pin_out  <= {W{1'b0}};
            bidir_pin_oe   <= {W{1'b0}};
            bidir_rd       <= `PPAF_BIDIR_RST;
            ana_mode_rd    <= `PPAF_ANA_RST;
            ana_digital_rd <= {W{1'b0}};
            spi_ss_n       <= 1'b1;
            uart_rx_din    <= 1'b1;
            spi_miso_in    <= 1'b1;
            irq_prio       <= 2'h0;
            timer_gate     <= 2'h0;
        end else begin
            bidir_pin_out  <= pin_out_d;
            bidir_pin_oe   <= pin_oe_d;
            bidir_rd       <= bidir_sync; // RL12
            ana_mode_rd    <= ana_mode_q;
            ana_digital_rd <= ana_sync & ~ana_mode_q; // RL1 RL3
            spi_ss_n       <= ana_mode_q[`PPAF_SS_BIT] | ana_sync[`PPAF_SS_BIT]; // RL10
            uart_rx_din    <= bidir_sync[`PPAF_RXD_BIT]; // RL9
            spi_miso_in    <= bidir_sync[`PPAF_IRQ1_BIT]; // RL11
            irq_prio       <= irq_prio_cfg; // RL7
            timer_gate     <= irq_lvl_n; // RL8
        end
    end
endmodule // ppaf_port_pins

/* common/ppaf_defines.vh */
/*
 constants for the port pin block: reset values, field positions, timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef PPAF_DEFINES_VH
`define PPAF_DEFINES_VH
`define PPAF_PORT_W        8
`define PPAF_ANA_RST       8'hFF
`define PPAF_BIDIR_RST     8'hFF
`define PPAF_RST_CYCLES    24
`define PPAF_RST_CNT_W     5
`define PPAF_SS_BIT        5
`define PPAF_RXD_BIT       0
`define PPAF_TXD_BIT       1
`define PPAF_IRQ0_BIT      2
`define PPAF_IRQ1_BIT      3
`define PPAF_SEL_GPIO      2'h0
`define PPAF_SEL_MISO      2'h1
`define PPAF_SEL_PWM       2'h2
`endif

/* hdl/ppaf_sync2.v */
/*
 two flip-flop synchroniser for a bus of pin levels.
 assumes levels asynchronous to clk; first stage read only by the second.
*/
`timescale 1ns/1ps
module ppaf_sync2 #(
    parameter W    = 8,
    parameter INIT = 0
) (
    clk,
    sys_rst,
    d,
    q
);
    input  wire         clk;
    input  wire         sys_rst;
    input  wire [W-1:0] d;
    output reg  [W-1:0] q;

    reg [W-1:0] meta_q;

    // two stage capture
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= INIT[W-1:0];
            q      <= INIT[W-1:0];
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // ppaf_sync2

/* dv/ppaf_port_pins_sva.sv */
/* checker for the port pin block.
 assumes it is bound to ppaf_port_pins and sees only its ports. */
`timescale 1ns/1ps
module ppaf_port_pins_sva #(
    parameter RST_CYCLES = 24
) (
    input logic       clk,
    input logic       sys_rst,
    input logic       reset_pin_in,
    input logic       bidir_wr,
    input logic [7:0] bidir_wdata,
    input logic [7:0] bidir_pin_in,
    input logic [7:0] bidir_pin_out,
    input logic [7:0] bidir_pin_oe,
    input logic [7:0] ana_pin_in,
    input logic [7:0] ana_mode_rd,
    input logic       spi_ss_n,
    input logic [1:0] irq_edge_mode,
    input logic [1:0] irq_clr,
    input logic [1:0] irq_req,
    input logic [1:0] timer_gate,
    input logic       core_rst_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    int hi_cnt_q;
    // counts consecutive high cycles of the raw reset pin
    always @(posedge clk or posedge sys_rst)
        if (sys_rst) hi_cnt_q <= 0;
        else hi_cnt_q <= reset_pin_in ? hi_cnt_q + 1 : 0;
    out_low_a: assert property (bidir_pin_out == 8'h00)
        else $error("pin output data not low");
    latch_drive_a: assert property (bidir_wr && !bidir_wdata[7] ##1 !bidir_wr
        |=> bidir_pin_oe[7]) else $error("zero latch does not drive pin");
    latch_release_a: assert property (bidir_wr && bidir_wdata[7] ##1 !bidir_wr
        |=> !bidir_pin_oe[7]) else $error("one latch does not release pin");
    rst_qualify_a: assert property ($rose(core_rst_req) |-> hi_cnt_q >= RST_CYCLES)
        else $error("reset request too early");
    rst_drop_a: assert property (!reset_pin_in [*5] |-> !core_rst_req)
        else $error("reset request stays after pin low");
    irq_level_a: assert property ((!irq_edge_mode[0] && !bidir_pin_in[2]) [*5]
        |-> irq_req[0]) else $error("level interrupt not raised");
    irq_sticky_a: assert property (irq_edge_mode[1] && irq_req[1] && !irq_clr[1]
        |=> irq_req[1]) else $error("edge flag lost without clear");
    gate_follow_a: assert property ($stable(bidir_pin_in[3:2]) [*5]
        |-> timer_gate == bidir_pin_in[3:2]) else $error("timer gate not pin level");
    ss_select_a: assert property ((!ana_mode_rd[5] && !ana_pin_in[5]) [*5]
        |-> !spi_ss_n) else $error("slave select not taken from pin");
    cover property ($rose(core_rst_req));
    cover property (irq_req[1]);
    cover property (!spi_ss_n);
endmodule // ppaf_port_pins_sva
bind ppaf_port_pins ppaf_port_pins_sva #(.RST_CYCLES(RST_CYCLES)) u_ppaf_port_pins_sva (.*);

/* dv/ppaf_board.sv */
/* board model: pull-ups on the bidirectional pins and external pull-downs.
 assumes an enable high means the block pulls the pin low. */
`timescale 1ns/1ps
module ppaf_board (
    input  logic [7:0] bidir_pin_oe,
    input  logic [7:0] ext_low,
    output logic [7:0] bidir_pin_in
);
    // released pins float up; a driven or pulled pin reads low
    assign bidir_pin_in = ~(bidir_pin_oe | ext_low);
endmodule // ppaf_board

/* dv/tb_ppaf_port_pins.sv */
/* self-checking bench for the port pin block.
 assumes the board model resolves the bidirectional pins. */
`timescale 1ns/1ps
module tb_ppaf_port_pins;
    logic       clk = 0, sys_rst = 1, reset_pin_in = 0, ana_wr = 0, bidir_wr = 0;
    logic [7:0] ana_wdata = 0, ana_pin_in = 0, bidir_wdata = 0, ext_low = 0;
    logic       uart_sync_mode = 0, uart_txd = 1, uart_sclk = 1, uart_rx_dout = 1;
    logic       uart_rx_doe = 0, spi_miso_en = 0, spi_miso_out = 1, pwm_route_en = 0;
    logic       pwm_output_first = 1;
    logic [1:0] irq_edge_mode = 0, irq_prio_cfg = 0, irq_clr = 0;
    wire  [7:0] ana_mode_rd, ana_digital_rd, bidir_pin_in, bidir_pin_out, bidir_pin_oe;
    wire  [7:0] bidir_rd;
    wire        spi_ss_n, uart_rx_din, spi_miso_in, core_rst_req;
    wire  [1:0] irq_req, irq_prio, timer_gate;
    int         bad_count = 0, tests_run = 0, cycles = 0;
    ppaf_port_pins u_ppaf_port_pins (.*);
    ppaf_board u_ppaf_board (.bidir_pin_oe(bidir_pin_oe), .ext_low(ext_low),
        .bidir_pin_in(bidir_pin_in));
    // 100 ns clock
    always #50 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_bidir(input logic [7:0] d);
        bidir_wr <= 1;
        bidir_wdata <= d;
        cyc(1);
        bidir_wr <= 0;
    endtask
    // one cycle write of the analog mode latch
    task automatic wr_ana(input logic [7:0] d);
        ana_wr <= 1;
        ana_wdata <= d;
        cyc(1);
        ana_wr <= 0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            final_report;
        end
    end
    // main sequence
    initial begin
        cyc(4);
        sys_rst <= 0;
        cyc(2);
        cmp("mode", 8'hff, ana_mode_rd);
        cmp("oe", 8'h00, bidir_pin_oe);
        cmp("ss", 8'h01, spi_ss_n);
        wr_bidir(8'h0f);
        cyc(5);
        cmp("oe", 8'hf0, bidir_pin_oe);
        cmp("out", 8'h00, bidir_pin_out);
        cmp("rd", 8'h0f, bidir_rd);
        ext_low <= 8'h01;
        cyc(4);
        cmp("rd", 8'h0e, bidir_rd);
        cmp("rxd", 8'h00, uart_rx_din);
        ext_low <= 8'h00;
        wr_bidir(8'hff);
        uart_txd <= 0;
        cyc(4);
        cmp("oe", 8'h02, bidir_pin_oe);
        uart_sync_mode <= 1;
        uart_sclk <= 0;
        uart_rx_doe <= 1;
        uart_rx_dout <= 0;
        cyc(4);
        cmp("oe", 8'h03, bidir_pin_oe);
        uart_sync_mode <= 0;
        uart_txd <= 1;
        uart_rx_doe <= 0;
        wr_ana(8'h00);
        ana_pin_in <= 8'ha5;
        cyc(5);
        cmp("mode", 8'h00, ana_mode_rd);
        cmp("dig", 8'ha5, ana_digital_rd);
        cmp("ss", 8'h01, spi_ss_n);
        ana_pin_in <= 8'h85;
        cyc(5);
        cmp("ss", 8'h00, spi_ss_n);
        ext_low <= 8'h04;
        irq_prio_cfg <= 2'b10;
        cyc(5);
        cmp("irq", 8'h01, irq_req);
        cmp("gate", 8'h02, timer_gate);
        cmp("prio", 8'h02, irq_prio);
        irq_edge_mode <= 2'b11;
        ext_low <= 8'h08;
        cyc(5);
        ext_low <= 8'h00;
        cyc(4);
        cmp("edge", 8'h01, irq_req[1]);
        irq_clr <= 2'b10;
        cyc(1);
        irq_clr <= 2'b00;
        cyc(2);
        cmp("clr", 8'h00, irq_req[1]);
        pwm_route_en <= 1;
        pwm_output_first <= 0;
        cyc(4);
        cmp("pwm", 8'h08, bidir_pin_oe);
        pwm_route_en <= 0;
        spi_miso_en <= 1;
        spi_miso_out <= 0;
        cyc(4);
        cmp("miso", 8'h08, bidir_pin_oe);
        cmp("miso_in", 8'h00, spi_miso_in);
        // pwm wins over miso: a high pwm level releases the pin
        pwm_route_en <= 1;
        pwm_output_first <= 1;
        cyc(4);
        cmp("pwm", 8'h00, bidir_pin_oe);
        pwm_route_en <= 0;
        spi_miso_en <= 0;
        // a pulse shorter than the qualify time is ignored
        reset_pin_in <= 1;
        cyc(20);
        reset_pin_in <= 0;
        cyc(8);
        cmp("rst", 8'h00, core_rst_req);
        // two sync edges plus 24 qualify edges before the request
        reset_pin_in <= 1;
        cyc(26);
        cmp("rst", 8'h00, core_rst_req);
        cyc(1);
        cmp("rst", 8'h01, core_rst_req);
        reset_pin_in <= 0;
        cyc(5);
        cmp("rst", 8'h00, core_rst_req);
        // mid-run reset restores the port defaults
        wr_bidir(8'h00);
        sys_rst <= 1;
        cyc(2);
        cmp("mode", 8'hff, ana_mode_rd);
        cmp("oe", 8'h00, bidir_pin_oe);
        cmp("irq", 8'h00, irq_req);
        sys_rst <= 0;
        cyc(2);
        wr_ana(8'hf0);
        cyc(5);
        cmp("mode", 8'hf0, ana_mode_rd);
        cmp("dig", 8'h05, ana_digital_rd);
        cmp("ss", 8'h01, spi_ss_n);
        cmp("oe", 8'h00, bidir_pin_oe);
        final_report;
    end
endmodule // tb_ppaf_port_pins
